// >>> src/mcd_map.svh
`ifndef MCD_MAP_SVH
`define MCD_MAP_SVH
`define MCD_ADDR_STATUS      7'h03
`define MCD_ADDR_POWER_DOWN_TRIGGER       7'h0A
`define MCD_IRQ_VECTOR       11'h001
`define MCD_RESET_VECTOR     11'h000
`define MCD_CFG_DEFAULT      14'h3FFF
`define MCD_ROM_PROTECT_VAL  14'h3FFF
`define MCD_CFG_PROTECT_BIT  13
`define MCD_CFG_CSS_HI       6
`define MCD_CFG_CSS_LO       5
`define MCD_CFG_LVS_HI       4
`define MCD_CFG_LVS_LO       0
`define MCD_ST_BANK          4
`define MCD_ST_Z             2
`define MCD_ST_DC            1
`define MCD_ST_C             0
`define MCD_STATUS_RESET     8'h00
`define MCD_STATUS_WMASK     8'h17
`define MCD_STACK_DEPTH      6
`define MCD_WDT_BITS         21
`define MCD_OSC_MHZ_STAB     10
`define MCD_STAB_US          2500
`define MCD_CLK_MHZ          250
`define MCD_STAB_CYCLES      (`MCD_STAB_US * `MCD_OSC_MHZ_STAB)
`define MCD_IRQ_SRC          5
`define MCD_OP_WATCHDOG_CLEAR_OP        14'h0089
`define MCD_OP_SLEEP         14'h008A
`define MCD_OP_RET           14'h0040
`define MCD_OP_INTERRUPT_RETURN_OP          14'h0060
`define MCD_OP_CLRW          14'h0140
`define MCD_PFX_ADD_FILE_OP        6'h07
`define MCD_PFX_ADD_LITERAL_OP        6'h1C
`define MCD_PFX_RETURN_LITERAL_OP        6'h18
`define MCD_PFX_MOVLW        6'h19
`define MCD_PFX_BTFSC        5'h0A
`define MCD_PFX_BTFSS        5'h0B
`define MCD_PFX_DECFSZ       6'h0B
`define MCD_PFX_INCFSZ       6'h0F
`define MCD_PFX_MOVWF        7'h01
`endif

// >>> src/mcd_pkg.sv
package mcd_pkg;
	typedef enum logic [1:0] {
		MCD_CLK_XTAL,
		MCD_CLK_EXT_RC,
		MCD_CLK_RC_SLOW,
		MCD_CLK_RC_FAST
	} mcd_clk_src_t;
	typedef enum logic [2:0] {
		MCD_DST_NONE,
		MCD_DST_ACC,
		MCD_DST_FILE
	} mcd_dst_t;
	typedef enum {
		MCD_S_STAB,
		MCD_S_RUN,
		MCD_S_SLEEP
	} mcd_state_t;
endpackage

// >>> src/mcd_stack.sv
`timescale 1ns/1ps
`include "mcd_map.svh"
module mcd_stack (
	input  wire logic        clk,      // core clock
	input  wire logic        rst,      // sync reset
	input  wire logic        push,     // push request
	input  wire logic        pop,      // pop request
	input  wire logic [10:0] push_data, // return address
	output logic      [10:0] stack_top  // registered top entry
);
	logic [10:0] ent_r   [`MCD_STACK_DEPTH];
	logic [10:0] ent_nxt [`MCD_STACK_DEPTH];
	genvar g;
	// a full stack wraps by dropping the oldest entry, as the hardware has no overflow flag
	generate
		for (g = 0; g < `MCD_STACK_DEPTH; g++) begin : g_ent
			always_comb begin
				ent_nxt[g] = ent_r[g];
				if (push)
					ent_nxt[g] = (g == 0) ? push_data : ent_r[(g == 0) ? 0 : g - 1];
				else if (pop)
					ent_nxt[g] = (g == `MCD_STACK_DEPTH - 1) ? 11'h000 : ent_r[(g == `MCD_STACK_DEPTH - 1) ? g : g + 1];
			end
			always_ff @(posedge clk) begin
				if (rst)
					ent_r[g] <= 11'h000;
				else
					ent_r[g] <= ent_nxt[g];
			end
		end
	endgenerate
	assign stack_top = ent_r[0];
endmodule // mcd_stack

// >>> src/mcd_wdt.sv
`timescale 1ns/1ps
`include "mcd_map.svh"
module mcd_wdt #(
	parameter logic [21:0] LIMIT = 22'h200000 // oscillator cycles before overflow
) (
	input  wire logic clk,      // core clock
	input  wire logic rst,      // sync reset
	input  wire logic osc_tick, // one pulse per oscillator cycle
	input  wire logic kick,     // clear-and-enable instruction
	input  wire logic halted,   // power-down, no counting
	output logic      expire    // one-cycle overflow pulse
);
	logic        en_r,  en_nxt;
	logic [21:0] cnt_r, cnt_nxt;
	logic        exp_r, exp_nxt;
	always_comb begin
		en_nxt  = en_r;
		cnt_nxt = cnt_r;
		exp_nxt = 1'b0;
		if (kick) begin
			en_nxt  = 1'b1; // RULE6
			cnt_nxt = 22'h000000; // RULE6
		end else if (en_r && !halted && osc_tick) begin // RULE8
			if (cnt_r == LIMIT - 22'h000001) begin
				exp_nxt = 1'b1; // RULE7
				cnt_nxt = 22'h000000;
			end else
				cnt_nxt = cnt_r + 22'h000001;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			en_r  <= 1'b0; // RULE6
			cnt_r <= 22'h000000;
			exp_r <= 1'b0;
		end else begin
			en_r  <= en_nxt;
			cnt_r <= cnt_nxt;
			exp_r <= exp_nxt;
		end
	end
	assign expire = exp_r;
	chk_wdt_off_reset: assert property (@(posedge clk) $past(rst) |-> !en_r) // RULE6
		else $error("watchdog enabled right after reset");
	chk_wdt_halt_hold: assert property (@(posedge clk) disable iff (rst) halted && !kick |=> $stable(cnt_r)) // RULE8
		else $error("watchdog counted in power-down");
endmodule // mcd_wdt

// >>> src/mcd_core.sv
`timescale 1ns/1ps
`include "mcd_map.svh"
// Contract
// RULE1: five interrupt sources, one vector; each has its own enable and own flag.
// RULE2: no hardware priority among sources; firmware orders pending ones.
// RULE3: pending enabled interrupt taken at instruction end as call to 0001, inhibit set.
// RULE4: inhibit clears one instruction after interrupt return; one main instruction runs.
// RULE5: flags set on edges and held until firmware clears them.
// RULE6: watchdog off after reset; clear instruction zeroes and enables it.
// RULE7: enabled watchdog resets chip after 2^21 oscillator cycles without clear.
// RULE8: watchdog frozen in power-down, never a wake source.
// RULE9: sleep instruction enters power-down, oscillator and peripherals stop.
// RULE10: power-down ends on reset or enabled external irq a/b, after stabilisation.
// RULE11: any write to address 0AH enters power-down like sleep.
// RULE12: power-on loads defaults; clock source and brown-out level from config word.
// RULE13: execution held about 2.5 ms after oscillator start.
// RULE14: config word at virtual 2000H, programmer-only, default 3FFFh.
// RULE15: config bit 13 zero makes every external ROM read return 3FFFh.
// RULE16: config bits 6-5 select crystal, external RC, slow or fast internal RC.
// RULE17: config bits 4-0 pick brown-out threshold; reset held while supply low.
// RULE18: each instruction is one 14-bit word with opcode and operand fields.
// RULE19: byte-op destination bit 0 writes accumulator, 1 writes file register.
// RULE20: top bits split byte, bit/literal, call and jump forms; 11-bit targets.
// RULE21: add-literal adds 8-bit literal to accumulator, updates C, DC, Z.
// RULE22: add-file adds accumulator and file, stores per d, updates C, DC, Z.
// RULE23: six-entry 11-bit stack; call and interrupt push, returns pop.
// RULE24: call pushes next address before loading 11-bit target.
// RULE25: flag-affecting write to status does not overwrite Z, DC, C.
// RULE26: call, jump, returns take two cycles; taken skip adds a no-op cycle.
module mcd_core #(
	parameter int STAB_CYCLES = `MCD_STAB_CYCLES // oscillator settle time in oscillator cycles
) (
	input  wire logic        clk,                    // 250 MHz core clock
	input  wire logic        rst,                    // power-on reset, sync high
	input  wire logic        osc_tick,               // one pulse per oscillator cycle
	input  wire logic        brownout_reset,         // supply below selected level
	input  wire logic [13:0] config_word,            // programmed option word
	input  wire logic        config_wr,              // programming system write strobe
	input  wire logic [13:0] rom_data,               // program word at rom_addr
	output logic      [10:0] rom_addr,               // program counter
	input  wire logic        ext_rom_rd,             // external read of program memory
	output logic      [13:0] ext_rom_data,           // ROM data seen externally
	input  wire logic [4:0]  irq_event,              // source edges, [0]=ext a, [1]=ext b
	input  wire logic [4:0]  irq_flag_clr,           // firmware flag clears
	input  wire logic [4:0]  irq_enable_reg,         // per-source enables
	output logic      [4:0]  irq_flags,              // sticky source flags
	input  wire logic [7:0]  file_rd_data,           // addressed file register
	output logic      [6:0]  file_addr,              // file register address
	output logic      [7:0]  file_wr_data,           // write data
	output logic             file_wr,                // file write strobe
	output logic      [7:0]  acc,                    // accumulator
	output logic      [7:0]  alu_flags_and_bank,     // status register
	output logic      [1:0]  clock_source_select,    // hi, lo
	output logic      [4:0]  brownout_level_select,  // threshold code
	output logic             osc_run,                // oscillator enabled
	output logic             core_hold,              // execution stalled
	output logic             chip_reset              // internal reset out
);
	logic [13:0] cfg_r, cfg_nxt;
	logic [10:0] pc_r, pc_nxt;
	logic [13:0] ir_r, ir_nxt;
	logic        flush_r, flush_nxt;
	logic [7:0]  acc_r, acc_nxt;
	logic [7:0]  st_r, st_nxt;
	logic [4:0]  flg_r, flg_nxt;
	logic [4:0]  evt_r;
	logic        inh_r, inh_nxt;
	logic        interrupt_return_op_r, interrupt_return_op_nxt;
	logic [31:0] stab_r, stab_nxt;
	logic [13:0] xrd_r, xrd_nxt;
	mcd_pkg::mcd_state_t st_state_r, st_state_nxt;
	logic        phase_r;
	logic        irq_take, push, pop, wdt_kick, wdt_exp, sys_rst, halt;
	logic        q2;
	logic [8:0]  sum;
	logic [4:0]  lsum;
	logic [7:0]  opnd, bitmask;
	logic        skip;
	logic        is_add, is_add_literal_op, is_add_file_op, wr_file, wr_acc;
	logic [10:0] stop;
	assign sys_rst = rst | brownout_reset | wdt_exp; // RULE17
	assign halt    = st_state_r != mcd_pkg::MCD_S_RUN;
	// execute slot: phase_r alone stands for two clk cycles, the tick picks exactly one
	assign q2      = phase_r && osc_tick;
	mcd_stack u_stack (
		.clk       (clk),
		.rst       (sys_rst),
		.push      (push),
		.pop       (pop),
		// a preempted word never ran and is the return point, unless its slot was flushed
		.push_data (irq_take && !flush_r ? pc_r - 11'd1 : pc_r),
		.stack_top (stop)
	);
	mcd_wdt u_wdt (
		.clk      (clk),
		.rst      (sys_rst),
		.osc_tick (osc_tick),
		.kick     (wdt_kick),
		.halted   (halt), // RULE8
		.expire   (wdt_exp)
	);
	// config word survives brown-out and watchdog resets; power-on reset loads the default, else only the programming path changes it
	always_comb begin
		cfg_nxt = config_wr ? config_word : cfg_r; // RULE14
	end
	always_ff @(posedge clk) begin
		if (rst)
			cfg_r <= `MCD_CFG_DEFAULT; // RULE14
		else
			cfg_r <= cfg_nxt;
	end
	assign clock_source_select   = cfg_r[`MCD_CFG_CSS_HI:`MCD_CFG_CSS_LO]; // RULE16 RULE12
	assign brownout_level_select = cfg_r[`MCD_CFG_LVS_HI:`MCD_CFG_LVS_LO]; // RULE17 RULE12
	always_comb begin
		xrd_nxt = xrd_r;
		if (ext_rom_rd)
			xrd_nxt = cfg_r[`MCD_CFG_PROTECT_BIT] ? rom_data : `MCD_ROM_PROTECT_VAL; // RULE15
	end
	always_ff @(posedge clk) begin
		if (rst)
			xrd_r <= 14'h0000;
		else
			xrd_r <= xrd_nxt;
	end
	assign ext_rom_data = xrd_r;
	// interrupt flags: set wins over clear
	always_comb begin
		flg_nxt = (flg_r & ~irq_flag_clr) | (irq_event & ~evt_r); // RULE1 RULE5
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			flg_r <= 5'h00;
			evt_r <= 5'h00;
		end else begin
			flg_r <= flg_nxt;
			evt_r <= irq_event;
		end
	end
	assign irq_flags = flg_r;
	// decode: single OR of all enabled flags, no priority
	assign irq_take = q2 && st_state_r == mcd_pkg::MCD_S_RUN && !inh_r
		&& |(flg_r & irq_enable_reg); // RULE2 RULE3
	assign is_add_literal_op = ir_r[13:8] == `MCD_PFX_ADD_LITERAL_OP; // RULE21
	assign is_add_file_op = ir_r[13:8] == `MCD_PFX_ADD_FILE_OP; // RULE22
	assign is_add   = is_add_literal_op | is_add_file_op;
	assign opnd     = is_add_literal_op ? ir_r[7:0] : file_rd_data;
	assign sum      = {1'b0, acc_r} + {1'b0, opnd};
	assign lsum     = {1'b0, acc_r[3:0]} + {1'b0, opnd[3:0]};
	assign bitmask  = 8'h01 << ir_r[8:6];
	// bit forms carry a 6-bit address, byte forms a 7-bit one
	assign file_addr = (ir_r[13:12] == 2'b01) ? {1'b0, ir_r[5:0]} : ir_r[6:0]; // RULE18
	always_comb begin
		skip = 1'b0;
		case (ir_r[13:9]) // RULE26
			`MCD_PFX_BTFSC: skip = (file_rd_data & bitmask) == 8'h00;
			`MCD_PFX_BTFSS: skip = (file_rd_data & bitmask) != 8'h00;
			default:        skip = 1'b0;
		endcase
		if (ir_r[13:8] == `MCD_PFX_DECFSZ)
			skip = file_rd_data == 8'h01;
		if (ir_r[13:8] == `MCD_PFX_INCFSZ)
			skip = file_rd_data == 8'hFF;
	end
	assign wr_file = !flush_r && ((ir_r[13:12] == 2'b00 && ir_r[7]) && ir_r[13:8] != 6'h00
		|| ir_r[13:7] == `MCD_PFX_MOVWF); // RULE19
	assign wr_acc  = !flush_r && (is_add_literal_op || is_add_file_op && !ir_r[7]); // RULE19
	assign file_wr      = q2 && !halt && !irq_take && (wr_file || !flush_r && ir_r[13:7] == `MCD_PFX_MOVWF);
	assign file_wr_data = is_add_file_op ? sum[7:0] : acc_r;
	assign wdt_kick = q2 && !flush_r && !irq_take && ir_r == `MCD_OP_WATCHDOG_CLEAR_OP && !halt; // RULE6
	assign push = q2 && !halt && (irq_take || !flush_r && ir_r[13:12] == 2'b10); // RULE23 RULE24
	assign pop  = q2 && !halt && !flush_r && !irq_take && (ir_r == `MCD_OP_RET
		|| ir_r == `MCD_OP_INTERRUPT_RETURN_OP || ir_r[13:8] == `MCD_PFX_RETURN_LITERAL_OP); // RULE23
	always_comb begin
		pc_nxt       = pc_r;
		ir_nxt       = ir_r;
		flush_nxt    = flush_r;
		acc_nxt      = acc_r;
		st_nxt       = st_r;
		inh_nxt      = inh_r;
		interrupt_return_op_nxt     = interrupt_return_op_r;
		stab_nxt     = stab_r;
		st_state_nxt = st_state_r;
		case (st_state_r)
			mcd_pkg::MCD_S_STAB: begin
				if (osc_tick) begin
					if (stab_r == 32'd0)
						st_state_nxt = mcd_pkg::MCD_S_RUN; // RULE13
					else
						stab_nxt = stab_r - 32'd1;
				end
			end
			mcd_pkg::MCD_S_SLEEP: begin
				if (|(flg_r[1:0] & irq_enable_reg[1:0])) begin // RULE10
					st_state_nxt = mcd_pkg::MCD_S_STAB;
					stab_nxt     = STAB_CYCLES - 1;
				end
			end
			mcd_pkg::MCD_S_RUN: begin
				if (q2) begin
					// Q2: fetch next, execute latched word
					ir_nxt    = rom_data; // RULE18
					pc_nxt    = pc_r + 11'd1;
					flush_nxt = 1'b0;
					// a flushed slot is no instruction; the inhibit waits for one that really runs
					if (interrupt_return_op_r && !flush_r) begin
						inh_nxt  = 1'b0; // RULE4
						interrupt_return_op_nxt = 1'b0;
					end
					if (irq_take) begin
						pc_nxt    = `MCD_IRQ_VECTOR; // RULE3
						inh_nxt   = 1'b1; // RULE3
						flush_nxt = 1'b1;
					end else if (!flush_r) begin
						case (ir_r[13:12]) // RULE20
							2'b10, 2'b11: begin
								pc_nxt    = ir_r[10:0]; // RULE24
								flush_nxt = 1'b1; // RULE26
							end
							default: begin
								if (pop) begin
									pc_nxt    = stop;
									flush_nxt = 1'b1; // RULE26
									if (ir_r == `MCD_OP_INTERRUPT_RETURN_OP)
										interrupt_return_op_nxt = 1'b1; // RULE4
								end
								if (skip)
									flush_nxt = 1'b1; // RULE26
							end
						endcase
						if (ir_r[13:8] == `MCD_PFX_RETURN_LITERAL_OP || ir_r[13:8] == `MCD_PFX_MOVLW)
							acc_nxt = ir_r[7:0];
						if (ir_r == `MCD_OP_CLRW)
							acc_nxt = 8'h00;
						if (wr_acc)
							acc_nxt = sum[7:0]; // RULE21 RULE22
						if (file_wr && file_addr == `MCD_ADDR_STATUS)
							st_nxt = (file_wr_data & `MCD_STATUS_WMASK) | (st_r & ~`MCD_STATUS_WMASK);
						if (is_add) begin
							st_nxt[`MCD_ST_C]  = sum[8]; // RULE25
							st_nxt[`MCD_ST_DC] = lsum[4];
							st_nxt[`MCD_ST_Z]  = sum[7:0] == 8'h00;
						end
						if (ir_r == `MCD_OP_SLEEP || file_wr && file_addr == `MCD_ADDR_POWER_DOWN_TRIGGER)
							st_state_nxt = mcd_pkg::MCD_S_SLEEP; // RULE9 RULE11
					end
				end
			end
			default: st_state_nxt = mcd_pkg::MCD_S_STAB;
		endcase
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pc_r       <= `MCD_RESET_VECTOR;
			ir_r       <= 14'h0000;
			flush_r    <= 1'b1;
			acc_r      <= 8'h00;
			st_r       <= `MCD_STATUS_RESET; // RULE12
			inh_r      <= 1'b0;
			interrupt_return_op_r     <= 1'b0;
			stab_r     <= STAB_CYCLES - 1; // RULE13
			st_state_r <= mcd_pkg::MCD_S_STAB;
			phase_r    <= 1'b0;
		end else begin
			pc_r       <= pc_nxt;
			ir_r       <= ir_nxt;
			flush_r    <= flush_nxt;
			acc_r      <= acc_nxt;
			st_r       <= st_nxt;
			inh_r      <= inh_nxt;
			interrupt_return_op_r     <= interrupt_return_op_nxt;
			stab_r     <= stab_nxt;
			st_state_r <= st_state_nxt;
			phase_r    <= (st_state_r == mcd_pkg::MCD_S_RUN && osc_tick) ? ~phase_r : phase_r;
		end
	end
	assign rom_addr           = pc_r;
	assign acc                = acc_r;
	assign alu_flags_and_bank = st_r;
	assign osc_run            = st_state_r != mcd_pkg::MCD_S_SLEEP; // RULE9
	assign core_hold          = halt;
	assign chip_reset         = sys_rst; // RULE7 RULE17
	chk_irq_vector_jump: assert property (@(posedge clk) disable iff (sys_rst) irq_take |=> pc_r == `MCD_IRQ_VECTOR && inh_r) // RULE3
		else $error("interrupt entry did not vector to 0001");
	chk_flag_sticky: assert property (@(posedge clk) disable iff (sys_rst) flg_r[1] && !irq_flag_clr[1] |=> flg_r[1]) // RULE5
		else $error("interrupt flag dropped without clear");
	chk_power_down_trigger_write: assert property (@(posedge clk) disable iff (sys_rst)
		file_wr && file_addr == `MCD_ADDR_POWER_DOWN_TRIGGER |=> st_state_r == mcd_pkg::MCD_S_SLEEP) // RULE11
		else $error("power-down write did not stop the core");
	chk_protect_read: assert property (@(posedge clk) disable iff (rst)
		ext_rom_rd && !cfg_r[`MCD_CFG_PROTECT_BIT] |=> ext_rom_data == `MCD_ROM_PROTECT_VAL) // RULE15
		else $error("protected ROM leaked");
	chk_call_push: assert property (@(posedge clk) disable iff (sys_rst)
		push && !irq_take |=> stop == $past(pc_r) && flush_r) // RULE24
		else $error("call pushed wrong address");
	chk_wake_source: assert property (@(posedge clk) disable iff (sys_rst)
		st_state_r == mcd_pkg::MCD_S_SLEEP && !(|(flg_r[1:0] & irq_enable_reg[1:0]))
		|=> st_state_r == mcd_pkg::MCD_S_SLEEP) // RULE10
		else $error("woke without external interrupt");
	chk_add_flags: assert property (@(posedge clk) disable iff (sys_rst)
		q2 && !halt && !flush_r && is_add_literal_op && !irq_take |=> st_r[`MCD_ST_C] == $past(sum[8])) // RULE21
		else $error("add carry wrong");
	chk_interrupt_return_op_inhibit: assert property (@(posedge clk) disable iff (sys_rst) interrupt_return_op_r |-> inh_r) // RULE4
		else $error("inhibit cleared too early");
endmodule // mcd_core

// >>> tb/mcd_mem_model.sv
`timescale 1ns/1ps
module mcd_mem_model (
	input  wire logic        clk,          // core clock
	input  wire logic [10:0] rom_addr,     // program counter from the core
	output logic      [13:0] rom_data,     // program word at rom_addr
	input  wire logic [6:0]  file_addr,    // file register address
	input  wire logic [7:0]  file_wr_data, // file write data
	input  wire logic        file_wr,      // file write strobe
	output logic      [7:0]  file_rd_data  // addressed file register
);
	logic [13:0] rom [0:2047];
	logic [7:0]  ram [0:127];

	// unloaded program words read as no-op so a stray fetch does nothing
	initial begin
		for (int i = 0; i < 2048; i++) begin
			rom[i] = 14'h0000;
		end
		for (int i = 0; i < 128; i++) begin
			ram[i] = 8'h00;
		end
	end

	assign rom_data     = rom[rom_addr];
	assign file_rd_data = ram[file_addr];

	always @(posedge clk) begin
		if (file_wr === 1'b1) begin
			ram[file_addr] <= file_wr_data;
		end
	end
endmodule // mcd_mem_model

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
	logic        clk = 1'b0, osc_tick = 1'b0, rst, brownout_reset, config_wr, ext_rom_rd;
	logic [13:0] config_word, rom_data, ext_rom_data;
	logic [10:0] rom_addr;
	logic [4:0]  irq_event, irq_flag_clr, irq_enable_reg, irq_flags, brownout_level_select;
	logic [7:0]  file_rd_data, file_wr_data, acc, alu_flags_and_bank;
	logic [6:0]  file_addr;
	logic        file_wr, osc_run, core_hold, chip_reset;
	logic [1:0]  clock_source_select;
	int          num_errors = 0;
	int          num_checks = 0;

	mcd_core #(.STAB_CYCLES(4)) uut (
		.clk(clk), .rst(rst), .osc_tick(osc_tick), .brownout_reset(brownout_reset),
		.config_word(config_word), .config_wr(config_wr), .rom_data(rom_data), .rom_addr(rom_addr),
		.ext_rom_rd(ext_rom_rd), .ext_rom_data(ext_rom_data), .irq_event(irq_event),
		.irq_flag_clr(irq_flag_clr), .irq_enable_reg(irq_enable_reg), .irq_flags(irq_flags),
		.file_rd_data(file_rd_data), .file_addr(file_addr), .file_wr_data(file_wr_data),
		.file_wr(file_wr), .acc(acc), .alu_flags_and_bank(alu_flags_and_bank),
		.clock_source_select(clock_source_select), .brownout_level_select(brownout_level_select),
		.osc_run(osc_run), .core_hold(core_hold), .chip_reset(chip_reset));

	mcd_mem_model mem (
		.clk(clk), .rom_addr(rom_addr), .rom_data(rom_data), .file_addr(file_addr),
		.file_wr_data(file_wr_data), .file_wr(file_wr), .file_rd_data(file_rd_data));

	always #2 clk = ~clk;

	// the oscillator stops while the core has it switched off
	always @(posedge clk) begin
		osc_tick <= (osc_run === 1'b1) ? ~osc_tick : 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic check(input bit ok, input string msg);
		num_checks++;
		if (!ok) begin
			num_errors++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask

	// sel 0: acc, 1: program counter, 2: oscillator enable
	task automatic wait_on(input int sel, input logic [10:0] v, input int lim);
		bit hit;
		hit = 0;
		for (int i = 0; i < lim && !hit; i++) begin
			tick(1);
			case (sel)
				0: hit = (acc === v[7:0]);
				1: hit = (rom_addr === v);
				default: hit = (osc_run === v[0]);
			endcase
		end
		check(hit, "expected value never arrived");
	endtask

	task automatic test_done();
		if (num_errors == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		#100us;
		num_errors++;
		test_done();
	end

	initial begin
		rst = 1'b1; brownout_reset = 1'b0; config_wr = 1'b0; ext_rom_rd = 1'b0;
		config_word = 14'h3FFF; irq_event = 5'h00; irq_flag_clr = 5'h00; irq_enable_reg = 5'h07;
		tick(5);
		// loaded after time zero so the memory's own clearing pass cannot wipe the program
		mem.rom[0] = 14'h3002; mem.rom[1] = 14'h3010; mem.rom[2] = 14'h1910; mem.rom[3] = 14'h1C15;
		mem.rom[4] = 14'h0720; mem.rom[5] = 14'h07A1; mem.rom[6] = 14'h200C; mem.rom[7] = 14'h008A;
		mem.rom[8] = 14'h3008; mem.rom[12] = 14'h0089; mem.rom[13] = 14'h0040; mem.rom[16] = 14'h0060;
		mem.ram[32] = 8'hC2; mem.ram[33] = 8'h19;
		check(uut.u_wdt.en_r === 1'b0, "watchdog enabled in reset");
		check(rom_addr === 11'h000 && irq_flags === 5'h00, "reset state wrong");
		check(clock_source_select === 2'h3 && brownout_level_select === 5'h1F, "config default wrong");
		rst = 1'b0;
		wait_on(0, 11'h010, 200);
		wait_on(0, 11'h025, 40);
		check(alu_flags_and_bank[2:0] === 3'h0, "add literal flags wrong");
		wait_on(0, 11'h0E7, 40);
		wait_on(1, 11'h00C, 40);
		check(acc === 8'hE7 && mem.ram[33] === 8'h00 && mem.ram[32] === 8'hC2, "add file routing wrong");
		check(alu_flags_and_bank[2:0] === 3'h7, "add file flags wrong");
		wait_on(1, 11'h007, 40);
		check(uut.u_wdt.en_r === 1'b1, "watchdog clear did not enable it");
		wait_on(2, 11'h000, 40);
		check(core_hold === 1'b1, "core not held in power-down");
		irq_event[2] = 1'b1;
		tick(20);
		check(osc_run === 1'b0 && irq_flags[2] === 1'b1, "internal source woke the core");
		irq_event[2] = 1'b0;
		irq_flag_clr[2] = 1'b1;
		tick(1);
		irq_flag_clr[2] = 1'b0;
		tick(1);
		check(irq_flags[2] === 1'b0, "flag clear ignored");
		irq_event[1] = 1'b1;
		wait_on(2, 11'h001, 40);
		check(core_hold === 1'b1, "no settle hold after wake");
		wait_on(1, 11'h001, 200);
		wait_on(1, 11'h010, 40);
		irq_event[1] = 1'b0;
		wait_on(1, 11'h008, 40);
		check(irq_flags[1] === 1'b1, "flag lost before firmware clear");
		wait_on(1, 11'h009, 8);
		wait_on(1, 11'h008, 8);
		wait_on(1, 11'h010, 40);
		irq_flag_clr[1] = 1'b1;
		irq_enable_reg = 5'h00;
		tick(1);
		irq_flag_clr[1] = 1'b0;
		tick(1);
		check(irq_flags === 5'h00 && chip_reset === 1'b0, "flags or reset wrong");
		brownout_reset = 1'b1;
		tick(2);
		check(chip_reset === 1'b1 && rom_addr === 11'h000, "brown-out reset missing");
		check(uut.u_wdt.en_r === 1'b0, "watchdog survived reset");
		brownout_reset = 1'b0;
		for (int c = 0; c < 4; c++) begin
			config_word = {1'b1, 6'h3F, 2'(c), 5'h19};
			config_wr = 1'b1;
			tick(1);
			config_wr = 1'b0;
			tick(1);
			check(clock_source_select === 2'(c) && brownout_level_select === 5'h19, "config select wrong");
		end
		config_word = {1'b0, 6'h3F, 2'h3, 5'h1F};
		config_wr = 1'b1;
		tick(1);
		config_wr = 1'b0;
		ext_rom_rd = 1'b1;
		tick(1);
		ext_rom_rd = 1'b0;
		tick(1);
		check(ext_rom_data === 14'h3FFF, "protected read leaked code");
		test_done();
	end
endmodule // tb
